//--- core/svwd_top.v
/*
 watchdog and reset timing of a quad supply supervisor.
 assumes the four comparator results arrive as asynchronous levels,
 timing capacitances are given as pF counts on static pins.
*/
// What this block does
// - while system reset is low, watchdog is cleared and fault output high
// - watchdog starts running when system reset releases high
// - each kick edge after start clears and restarts the watchdog
// - timeout without a kick edge drives fault output low
// - after timeout fault stays low, timer cleared, until kick edge or reset
// - reset-pulse variant: missed kick drives system reset low one reset timeout
// - zero watchdog capacitance disables the watchdog completely
// - with watchdog disabled, reset forces fault output high forever
// - open kick input reads high through a weak pull-up
// - reset timeout scales linearly at 217 pF per ms
// - no reset capacitor gives the 50 us minimum reset timeout
// - watchdog timeout scales linearly at 50 pF per ms
// - no watchdog capacitor gives the 200 us minimum watchdog timeout
// - each monitored supply has its own comparator output
// - reset asserted if any supply low, released only when all good
// - low supply holds system reset and its comparator output low
`timescale 1ns/10ps
`default_nettype none
`include "svwd_defines.vh"
module svwd_top #(
    // 1: watchdog fault output; 0: watchdog pulses system reset
    parameter FAULT_VARIANT = 1
) (
    // clock and reset
    input wire MCLK,
    input wire RST,
    // supply comparator results, high when above threshold
    input wire [`SVWD_NSUP-1:0] SUPPLY_OK,
    // watchdog kick pin, with driver presence flag
    input wire WATCHDOG_KICK_IN,
    input wire WATCHDOG_KICK_DRIVEN,
    // timing capacitances in pF; zero watchdog cap means grounded pin
    input wire [`SVWD_CAP_W-1:0] RESET_TIMING_CAP,
    input wire [`SVWD_CAP_W-1:0] WATCHDOG_TIMING_CAP,
    input wire WATCHDOG_TIMING_CAP_OPEN,
    // outputs
    output reg SYSTEM_RESET_N,
    output reg WATCHDOG_FAULT_N,
    output reg [`SVWD_NSUP-1:0] SUPPLY_COMPARE_OUT
);
    localparam [`SVWD_CNT_W-1:0] RST_MIN = `SVWD_RST_MIN_CYC;
    localparam [`SVWD_CNT_W-1:0] WD_MIN = `SVWD_WD_MIN_CYC;
    localparam [`SVWD_CNT_W-1:0] CYC_MS = `SVWD_CYC_PER_MS;

    localparam [1:0] ST_HOLD = 2'h0;
    localparam [1:0] ST_DELAY = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    wire [`SVWD_NSUP-1:0] sup_s;
    wire kick_raw;
    wire kick_s;
    wire all_ok;
    wire rst_done;
    wire wd_done;
    wire wd_disabled;
    reg [`SVWD_CNT_W-1:0] rst_len;
    reg [`SVWD_CNT_W-1:0] wd_len;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg kick_prev_q;
    reg wd_ran_q;
    reg wd_latch_q;
    reg rst_clear;
    reg rst_start;
    reg wd_clear;
    reg wd_start;
    reg kick_edge;
    wire [`SVWD_CAP_W-1:0] rcap_s;
    wire [`SVWD_CAP_W-1:0] wcap_s;
    wire wopen_s;
    reg [63:0] rst_prod;
    reg [63:0] rst_quot;
    reg [63:0] wd_prod;
    reg [63:0] wd_quot;

    // weak pull-up: an undriven pin reads high
    assign kick_raw = WATCHDOG_KICK_DRIVEN ? WATCHDOG_KICK_IN : 1'b1;
    assign all_ok = &sup_s;
    assign wd_disabled = (wcap_s == {`SVWD_CAP_W{1'b0}})
        && !wopen_s;

    genvar gi;
    generate
        for (gi = 0; gi < `SVWD_NSUP; gi = gi + 1) begin : g_sup
            svwd_sync #(.RESET_VAL(1'b0)) u_sync (
                .clk(MCLK),
                .rst(RST),
                .din(SUPPLY_OK[gi]),
                .dout(sup_s[gi])
            );
        end
    endgenerate

    svwd_sync #(.RESET_VAL(1'b1)) u_kick_sync (
        .clk(MCLK),
        .rst(RST),
        .din(kick_raw),
        .dout(kick_s)
    );

    // straps are static; bits sync one by one, so a strap moved while
    // running may be seen torn for a cycle
    generate
        for (gi = 0; gi < `SVWD_CAP_W; gi = gi + 1) begin : g_cap
            svwd_sync #(.RESET_VAL(1'b0)) u_rcap_sync (
                .clk(MCLK),
                .rst(RST),
                .din(RESET_TIMING_CAP[gi]),
                .dout(rcap_s[gi])
            );
            svwd_sync #(.RESET_VAL(1'b0)) u_wcap_sync (
                .clk(MCLK),
                .rst(RST),
                .din(WATCHDOG_TIMING_CAP[gi]),
                .dout(wcap_s[gi])
            );
        end
    endgenerate

    // reset as open: minimum timeout until the pin is seen
    svwd_sync #(.RESET_VAL(1'b1)) u_open_sync (
        .clk(MCLK),
        .rst(RST),
        .din(WATCHDOG_TIMING_CAP_OPEN),
        .dout(wopen_s)
    );

    // timeout lengths: floor at minimum, else linear in capacitance
    // full-width product: a large cap would wrap the count width before the divide
    always @* begin
        rst_prod = {40'h0, rcap_s} * {24'h0, CYC_MS};
        rst_quot = rst_prod / `SVWD_RST_PF_PER_MS;
        rst_len = rst_quot[`SVWD_CNT_W-1:0];
        if (rst_len < RST_MIN) begin
            rst_len = RST_MIN;
        end
        wd_prod = {40'h0, wcap_s} * {24'h0, CYC_MS};
        wd_quot = wd_prod / `SVWD_WD_PF_PER_MS;
        if (wopen_s) begin
            wd_len = WD_MIN;
        end else begin
            wd_len = wd_quot[`SVWD_CNT_W-1:0];
            if (wd_len < WD_MIN) begin
                wd_len = WD_MIN;
            end
        end
    end

    svwd_timer #(.W(`SVWD_CNT_W)) u_rst_timer (
        .clk(MCLK),
        .rst(RST),
        .clear(rst_clear),
        .start(rst_start),
        .length(rst_len),
        .running(),
        .expired(rst_done)
    );

    svwd_timer #(.W(`SVWD_CNT_W)) u_wd_timer (
        .clk(MCLK),
        .rst(RST),
        .clear(wd_clear),
        .start(wd_start),
        .length(wd_len),
        .running(),
        .expired(wd_done)
    );

    // reset sequencing
    always @* begin
        state_d = state_q;
        rst_clear = 1'b0;
        rst_start = 1'b0;
        case (state_q)
            ST_HOLD: begin
                rst_clear = 1'b1;
                if (all_ok) begin
                    rst_start = 1'b1;
                    rst_clear = 1'b0;
                    state_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!all_ok) begin
                    // any dip restarts the full delay
                    rst_clear = 1'b1;
                    state_d = ST_HOLD;
                end else if (rst_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!all_ok) begin
                    state_d = ST_HOLD;
                end else if (FAULT_VARIANT == 0 && wd_done && !kick_edge) begin
                    // a kick in the expiry cycle still wins
                    rst_start = 1'b1;
                    state_d = ST_DELAY;
                end
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
    end

    // watchdog control
    always @* begin
        kick_edge = (kick_s != kick_prev_q);
        wd_clear = 1'b0;
        wd_start = 1'b0;
        if (state_q != ST_RUN || wd_disabled) begin
            wd_clear = 1'b1;
        end else if (!wd_ran_q) begin
            wd_start = 1'b1;
        end else if (kick_edge) begin
            wd_start = 1'b1;
        end else if (wd_latch_q) begin
            wd_clear = 1'b1;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_HOLD;
            kick_prev_q <= 1'b1;
            wd_ran_q <= 1'b0;
            wd_latch_q <= 1'b0;
            SYSTEM_RESET_N <= 1'b0;
            WATCHDOG_FAULT_N <= 1'b1;
            SUPPLY_COMPARE_OUT <= {`SVWD_NSUP{1'b0}};
        end else begin
            state_q <= state_d;
            kick_prev_q <= kick_s;
            SUPPLY_COMPARE_OUT <= sup_s;
            SYSTEM_RESET_N <= (state_d == ST_RUN);
            if (state_q != ST_RUN || wd_disabled) begin
                wd_ran_q <= 1'b0;
                wd_latch_q <= 1'b0;
                WATCHDOG_FAULT_N <= 1'b1;
            end else begin
                wd_ran_q <= 1'b1;
                if (kick_edge) begin
                    wd_latch_q <= 1'b0;
                    WATCHDOG_FAULT_N <= 1'b1;
                end else if (wd_done && FAULT_VARIANT != 0) begin
                    wd_latch_q <= 1'b1;
                    WATCHDOG_FAULT_N <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- core/svwd_defines.vh
/*
 constants for the supervisor watchdog and reset timing block.
 assumes a 250 MHz design clock (4 ns period).
*/
`ifndef SVWD_DEFINES_VH
`define SVWD_DEFINES_VH

`define SVWD_CLK_PS 4000
// reset timing: pF of capacitance per ms of delay
`define SVWD_RST_PF_PER_MS 217
// minimum reset timeout, no capacitor fitted, in us
`define SVWD_RST_MIN_US 50
// watchdog timing: pF of capacitance per ms of delay
`define SVWD_WD_PF_PER_MS 50
// minimum watchdog timeout, no capacitor fitted, in us
`define SVWD_WD_MIN_US 200
// cycles in one microsecond at 250 MHz
`define SVWD_CYC_PER_US (1000000 / `SVWD_CLK_PS)
`define SVWD_RST_MIN_CYC (`SVWD_RST_MIN_US * `SVWD_CYC_PER_US)
`define SVWD_WD_MIN_CYC (`SVWD_WD_MIN_US * `SVWD_CYC_PER_US)
// cycles in one ms, scaled per pF below
`define SVWD_CYC_PER_MS (1000 * `SVWD_CYC_PER_US)
`define SVWD_CNT_W 40
`define SVWD_CAP_W 24
`define SVWD_NSUP 4

`endif

//--- core/svwd_sync.v
/*
 three-flop input synchroniser with agreement on the last two stages.
 assumes a free-running clock and an asynchronous, active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module svwd_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk,
    input wire rst,
    input wire din,
    output reg dout
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // first stage is read only by the second
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

//--- core/svwd_timer.v
/*
 loadable down counter used for the reset and watchdog timeouts.
 assumes the caller holds clear while the timer must stay idle.
*/
`timescale 1ns/10ps
`default_nettype none
module svwd_timer #(
    parameter W = 40
) (
    input wire clk,
    input wire rst,
    input wire clear,
    input wire start,
    input wire [W-1:0] length,
    output wire running,
    output reg expired
);
    reg [W-1:0] cnt_q;
    reg run_q;

    assign running = run_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
            run_q <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (clear) begin
                cnt_q <= {W{1'b0}};
                run_q <= 1'b0;
            end else if (start) begin
                cnt_q <= length;
                run_q <= 1'b1;
            end else if (run_q) begin
                if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
                    run_q <= 1'b0;
                    expired <= 1'b1;
                    cnt_q <= {W{1'b0}};
                end else begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/svwd_props_properties.sv
/* port checker for svwd_top.
   assumes minimum timing figures when the timing pins read unfitted. */
`timescale 1ns/10ps
`default_nettype none
`include "svwd_defines.vh"
module svwd_props #(
    parameter FAULT_VARIANT = 1
) (
    // clock and reset
    input wire MCLK,
    input wire RST,
    // watched ports
    input wire [`SVWD_NSUP-1:0] SUPPLY_OK,
    input wire WATCHDOG_KICK_IN,
    input wire WATCHDOG_KICK_DRIVEN,
    input wire [`SVWD_CAP_W-1:0] RESET_TIMING_CAP,
    input wire [`SVWD_CAP_W-1:0] WATCHDOG_TIMING_CAP,
    input wire WATCHDOG_TIMING_CAP_OPEN,
    input wire SYSTEM_RESET_N,
    input wire WATCHDOG_FAULT_N,
    input wire [`SVWD_NSUP-1:0] SUPPLY_COMPARE_OUT
);
    localparam int RST_CYC = `SVWD_RST_MIN_CYC;
    localparam int WD_CYC = `SVWD_WD_MIN_CYC;
    // open pin reads high, so the stale driver value must not count
    wire kick_lvl = WATCHDOG_KICK_DRIVEN ? WATCHDOG_KICK_IN : 1'b1;
    reg kick_q;
    reg [19:0] idle_q;
    reg [15:0] good_q;
    reg [15:0] low_q;
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            kick_q <= 1'b1;
            idle_q <= 20'h0;
            good_q <= 16'h0;
            low_q <= 16'h0;
        end else begin
            kick_q <= kick_lvl;
            idle_q <= (kick_lvl != kick_q || !SYSTEM_RESET_N) ? 20'h0 : idle_q + {19'h0, ~&idle_q};
            good_q <= (&SUPPLY_OK) ? good_q + {15'h0, ~&good_q} : 16'h0;
            low_q <= SYSTEM_RESET_N ? 16'h0 : low_q + {15'h0, ~&low_q};
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    chk_fault_in_reset: assert property (!SYSTEM_RESET_N && $past(!SYSTEM_RESET_N) |-> WATCHDOG_FAULT_N)
        else $error("fault low during reset");
    chk_start_quiet: assert property ($rose(SYSTEM_RESET_N) |-> WATCHDOG_FAULT_N [*8])
        else $error("fault right after release");
    chk_timeout_len: assert property ($fell(WATCHDOG_FAULT_N) && WATCHDOG_TIMING_CAP_OPEN
        |-> idle_q >= WD_CYC - 2 && idle_q <= WD_CYC + 12)
        else $error("watchdog timeout length wrong");
    chk_fault_release: assert property ($rose(WATCHDOG_FAULT_N) |-> idle_q < 20'hc)
        else $error("fault released without kick");
    chk_wd_disabled: assert property (!WATCHDOG_TIMING_CAP_OPEN && WATCHDOG_TIMING_CAP == 0
        |-> WATCHDOG_FAULT_N)
        else $error("fault with watchdog off");
    chk_low_supply: assert property (!(&SUPPLY_OK) [*8] |-> !SYSTEM_RESET_N && !(&SUPPLY_COMPARE_OUT))
        else $error("low supply not flagged");
    chk_compare_copy: assert property ($stable(SUPPLY_OK) [*8] |-> SUPPLY_COMPARE_OUT == SUPPLY_OK)
        else $error("compare output differs");
    chk_release_delay: assert property ($rose(SYSTEM_RESET_N) && RESET_TIMING_CAP == 0
        |-> good_q >= RST_CYC && low_q >= RST_CYC - 1)
        else $error("reset released early");
    chk_variant_fault: assert property (FAULT_VARIANT == 0 |-> WATCHDOG_FAULT_N)
        else $error("fault pin active in pulse variant");
    cover property ($rose(SYSTEM_RESET_N));
    cover property ($fell(WATCHDOG_FAULT_N));
    cover property ($rose(WATCHDOG_FAULT_N));
endmodule
bind svwd_top svwd_props #(.FAULT_VARIANT(FAULT_VARIANT)) u_props (.MCLK(MCLK), .RST(RST), .SUPPLY_OK(SUPPLY_OK),
    .WATCHDOG_KICK_IN(WATCHDOG_KICK_IN), .WATCHDOG_KICK_DRIVEN(WATCHDOG_KICK_DRIVEN),
    .RESET_TIMING_CAP(RESET_TIMING_CAP), .WATCHDOG_TIMING_CAP(WATCHDOG_TIMING_CAP),
    .WATCHDOG_TIMING_CAP_OPEN(WATCHDOG_TIMING_CAP_OPEN), .SYSTEM_RESET_N(SYSTEM_RESET_N),
    .WATCHDOG_FAULT_N(WATCHDOG_FAULT_N), .SUPPLY_COMPARE_OUT(SUPPLY_COMPARE_OUT));
`default_nettype wire

//--- verification/svwd_host_model.sv
/* host that kicks the watchdog pin.
   assumes the bench calls its tasks; pin changes land on falling edges. */
`timescale 1ns/10ps
`default_nettype none
module svwd_host_model (
    // clock
    input wire logic clk,
    // kick pin
    output logic kick_in,
    output logic kick_driven
);
    initial begin
        kick_in = 1'b0;
        kick_driven = 1'b0;
    end
    task drive_low;
        @(negedge clk);
        kick_driven = 1'b1;
        kick_in = 1'b0;
    endtask
    // stale low stays on the driver, only the pull-up may lift the pin
    task release_pin;
        @(negedge clk);
        kick_driven = 1'b0;
        kick_in = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verification/supervisor_watchdog_reset_test.sv
/* bench for the watchdog and reset timing block.
   assumes unfitted timing caps, so the minimum counts keep the run short. */
`timescale 1ns/10ps
`default_nettype none
module supervisor_watchdog_reset_test;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [3:0] sup = 4'hf;
    logic [23:0] cap0 = 24'h0;
    logic open_on = 1'b1;
    logic open_off = 1'b0;
    wire kick, driven, rst_n, fault_n, rp_rst_n, off_f;
    wire [3:0] cmp;
    // own supplies, so a dip can land while this copy's fault is low
    logic [3:0] sup_d = 4'hf;
    wire rst_n_d, fault_d;
    wire [3:0] cmp_d;
    int fail_count = 0;
    int total_checks = 0;
    int n;
    initial begin
        forever #2 MCLK = ~MCLK;
    end
    svwd_host_model u_host (.clk(MCLK), .kick_in(kick), .kick_driven(driven));
    svwd_top #(.FAULT_VARIANT(1)) u_dut (.MCLK(MCLK), .RST(RST), .SUPPLY_OK(sup), .WATCHDOG_KICK_IN(kick),
        .WATCHDOG_KICK_DRIVEN(driven), .RESET_TIMING_CAP(cap0), .WATCHDOG_TIMING_CAP(cap0),
        .WATCHDOG_TIMING_CAP_OPEN(open_on), .SYSTEM_RESET_N(rst_n), .WATCHDOG_FAULT_N(fault_n),
        .SUPPLY_COMPARE_OUT(cmp));
    svwd_top #(.FAULT_VARIANT(0)) u_dut_rp (.MCLK(MCLK), .RST(RST), .SUPPLY_OK(sup), .WATCHDOG_KICK_IN(kick),
        .WATCHDOG_KICK_DRIVEN(driven), .RESET_TIMING_CAP(cap0), .WATCHDOG_TIMING_CAP(cap0),
        .WATCHDOG_TIMING_CAP_OPEN(open_on), .SYSTEM_RESET_N(rp_rst_n), .WATCHDOG_FAULT_N(),
        .SUPPLY_COMPARE_OUT());
    svwd_top #(.FAULT_VARIANT(1)) u_dut_off (.MCLK(MCLK), .RST(RST), .SUPPLY_OK(sup), .WATCHDOG_KICK_IN(kick),
        .WATCHDOG_KICK_DRIVEN(driven), .RESET_TIMING_CAP(cap0), .WATCHDOG_TIMING_CAP(cap0),
        .WATCHDOG_TIMING_CAP_OPEN(open_off), .SYSTEM_RESET_N(), .WATCHDOG_FAULT_N(off_f),
        .SUPPLY_COMPARE_OUT());
    svwd_top #(.FAULT_VARIANT(1)) u_dut_dip (.MCLK(MCLK), .RST(RST), .SUPPLY_OK(sup_d), .WATCHDOG_KICK_IN(kick),
        .WATCHDOG_KICK_DRIVEN(driven), .RESET_TIMING_CAP(cap0), .WATCHDOG_TIMING_CAP(cap0),
        .WATCHDOG_TIMING_CAP_OPEN(open_on), .SYSTEM_RESET_N(rst_n_d), .WATCHDOG_FAULT_N(fault_d),
        .SUPPLY_COMPARE_OUT(cmp_d));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_power_up;
        n = 0;
        while (rst_n !== 1'b1 && n < 13000) begin
            @(negedge MCLK);
            n++;
        end
        check(n >= 12500 && n < 13000, 1'h1);
        check({fault_n, cmp}, 5'h1f);
    endtask
    // kick 10000 cycles into the window, then starve: a kick that fails to clear shows up early
    task automatic t_timeout;
        repeat (10000) @(negedge MCLK);
        u_host.drive_low();
        n = 0;
        while (fault_n === 1'b1 && n < 60000) begin
            @(negedge MCLK);
            n++;
        end
        check(n > 49990 && n < 50012, 1'h1);
        repeat (8) @(negedge MCLK);
        check({rp_rst_n, off_f}, 2'h1);
        n = 0;
        while (rp_rst_n !== 1'b1 && n < 13000) begin
            @(negedge MCLK);
            n++;
        end
        check(n > 12480 && n < 12520, 1'h1);
        check(fault_n, 1'h0);
    endtask
    // dip while the fault is latched low: reset must lift it
    task automatic t_dip_fault;
        sup_d = 4'h7;
        repeat (8) @(negedge MCLK);
        check({rst_n_d, fault_d, cmp_d}, 6'h17);
        check(fault_n, 1'h0);
    endtask
    task automatic t_recover;
        u_host.release_pin();
        repeat (10) @(negedge MCLK);
        check(fault_n, 1'h1);
    endtask
    task automatic t_dip;
        sup = 4'hb;
        repeat (8) @(negedge MCLK);
        check({rst_n, cmp}, 5'h0b);
        check(fault_n, 1'h1);
    endtask
    initial begin
        repeat (5) @(negedge MCLK);
        RST = 1'b0;
        t_power_up();
        t_timeout();
        t_dip_fault();
        t_recover();
        t_dip();
        report_and_stop();
    end
    // hang guard, above the expected run of about 85000 cycles
    initial begin
        repeat (100000) @(posedge MCLK);
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
